// ==== pvb_defs.svh ====
// constants for the print video band controller: offsets, fields, resets, sizes
//
// Operation
// RULE1: five event flags: band begin, page end, video, band and address errors.
// RULE2: after any error the controller needs a soft reset to recover; the code halts only on an address error.
// RULE3: busy flag stays high while a print operation executes.
// RULE4: software loads the control block only while block-full is clear.
// RULE5: at page start, band begin is posted once frame sync arrives.
// RULE6: a mid-page band posts band begin at its first memory read.
// RULE7: page end is posted right after the last word of a page is fetched.
// RULE8: band underrun when a continued band ends with no next address loaded.
// RULE9: video underrun when the engine wants dots faster than fetches deliver.
// RULE10: illegal fetch address sets a flag and halts until soft reset.
// RULE11: address write sets full and busy; full clears once video starts.
// RULE12: sequencer waits frame sync, posts begin, then waits line sync.
// RULE13: line syncs count vertical margin, then dots count horizontal margin.
// RULE14: sixteen-bit shift register, one bit per dot, reloaded when empty.
// RULE15: each dot decrements width; at zero height decrements, next line waits.
// RULE16: fetching stops when height and width are done; busy then clears.
// RULE17: at end post page end and idle, or end-of-band idle if continued.
// RULE18: synchronous mode uses the engine clock directly, on the selected edge.
// RULE19: a synchronous engine gives a free-running dot clock and aligned line sync.
// RULE20: asynchronous mode input clock runs 4 to 32 times the dot rate.
// RULE21: asynchronous dot clock realigns on every line sync, one dot delay; the code realigns only while the sequencer is not in S_IDLE.
// RULE22: reset selects synchronous mode; source changes need a soft reset.
// RULE23: software sets the continuation bit for every band but the last.
`ifndef PVB_DEFS_SVH
`define PVB_DEFS_SVH
`define PVB_OFF_CTRL 8'h00
`define PVB_OFF_VMAR 8'h04
`define PVB_OFF_HMAR 8'h08
`define PVB_OFF_HGT 8'h0c
`define PVB_OFF_WID 8'h10
`define PVB_OFF_BCTL 8'h14
`define PVB_OFF_ADDR 8'h18
`define PVB_OFF_EVT 8'h1c
`define PVB_OFF_SRST 8'h20
`define PVB_EV_BEG 0
`define PVB_EV_END 1
`define PVB_EV_VUN 2
`define PVB_EV_BUN 3
`define PVB_EV_BAD 4
`define PVB_ST_FULL 8
`define PVB_ST_BUSY 9
`define PVB_CTRL_RST 6'h00
`define PVB_MEM_LIMIT 20'h80000
`define PVB_FIFO_DEPTH 4'h4
`define PVB_WORD_BITS 5'h10
`endif

// ==== pvb_pkg.sv ====
// types shared by the print video band controller
package pvb_pkg;
    typedef enum logic [2:0] {S_IDLE, S_FRAME, S_LINE, S_HMAR, S_ACT, S_BAND, S_HALT} pvb_state_t;
    typedef struct packed {
        logic [15:0] vmargin;
        logic [15:0] hmargin;
        logic [15:0] height;
        logic [15:0] width;
        logic [23:0] addr;
        logic band;
    } pvb_blk_t;
    typedef struct packed {
        logic [2:0] mult;
        logic pout;
        logic edge_sel;
        logic src;
    } pvb_ctrl_t;
    typedef struct packed {
        logic req;
        logic [19:0] addr;
    } pvb_memreq_t;
    typedef struct packed {
        logic ack;
        logic err;
        logic [15:0] data;
    } pvb_memrsp_t;
endpackage : pvb_pkg

// ==== pvb_sync.sv ====
// two-flop synchroniser for engine pins
`timescale 1ns/1ps
module pvb_sync #(parameter int W = 3) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : pvb_sync

// ==== pvb_top.sv ====
// print video band controller: apb registers, image fetch, fifo, video sequencer
`timescale 1ns/1ps
`include "pvb_defs.svh"
module pvb_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output pvb_pkg::pvb_memreq_t mem_cmd,
    input wire pvb_pkg::pvb_memrsp_t mem_rsp,
    input wire logic frame_sync_in,
    input wire logic line_sync_in,
    input wire logic engine_dot_clock_in,
    output logic video_out,
    output logic print_out
);
    import pvb_pkg::*;

    pvb_ctrl_t video_control_reg;
    pvb_blk_t stg;
    pvb_blk_t act;
    pvb_state_t st;
    logic [4:0] video_event_status;
    logic control_block_full_flag;
    logic video_busy_flag;
    logic soft_rst;
    logic [2:0] pin_q;
    logic [2:0] pin_prev;
    logic frame_rise;
    logic line_rise;
    logic clk_rise;
    logic clk_fall;
    logic dot_tick;
    logic [5:0] dcnt;
    logic [5:0] mult;
    logic access;
    logic wr;
    logic take;
    logic [15:0] fifo_mem [0:3];
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    logic [2:0] fcount;
    logic fifo_empty;
    logic fetch_on;
    logic [19:0] faddr;
    logic [12:0] fwords;
    logic [15:0] flines;
    logic first_fetch;
    logic f_beg;
    logic f_end;
    logic f_bun;
    logic f_bad;
    logic f_done;
    logic seq_beg;
    logic seq_vun;
    logic [15:0] vm_cnt;
    logic [15:0] hm_cnt;
    logic [15:0] wcnt;
    logic [15:0] lines;
    logic [15:0] sh_reg;
    logic [4:0] sh_cnt;
    logic [16:0] wsum;
    logic [12:0] wpl;

    // words fetched per scanline, rounded up
    assign wsum = {1'b0, act.width} + 17'h0000f;
    assign wpl = wsum[16:4];
    assign fcount = wr_ptr - rd_ptr;
    assign fifo_empty = (fcount == 3'h0);
    assign access = psel && penable && pready;
    assign wr = access && pwrite;
    assign take = control_block_full_flag && !fetch_on && (st == S_IDLE || st == S_BAND);

    // engine pins cross into pclk
    pvb_sync #(.W(3)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({engine_dot_clock_in, line_sync_in, frame_sync_in}),
        .q(pin_q)
    );

    // edge detection on synchronised pins, active high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev <= 3'h0;
        end else begin
            pin_prev <= pin_q;
        end
    end
    assign frame_rise = pin_q[0] && !pin_prev[0];
    assign line_rise = pin_q[1] && !pin_prev[1];
    assign clk_rise = pin_q[2] && !pin_prev[2];
    assign clk_fall = !pin_q[2] && pin_prev[2];

    // input clock multiple in asynchronous mode
    always_comb begin
        case (video_control_reg.mult)
            3'h0: mult = 6'h04;
            3'h1: mult = 6'h08;
            3'h2: mult = 6'h0c;
            3'h3: mult = 6'h10;
            3'h4: mult = 6'h18;
            default: mult = 6'h20; // RULE20
        endcase
    end

    // dot enable: engine clock edge, or divided clock realigned on line sync
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dcnt <= 6'h00;
            dot_tick <= 1'b0;
        end else begin
            dot_tick <= 1'b0;
            if (!video_control_reg.src) begin
                dot_tick <= video_control_reg.edge_sel ? clk_rise : clk_fall; // RULE18 RULE19
                dcnt <= 6'h00;
            end else if (line_rise && st != S_IDLE) begin
                dcnt <= 6'h00; // RULE21
            end else if (clk_rise) begin
                if (dcnt == mult - 6'h01) begin
                    dcnt <= 6'h00;
                    dot_tick <= 1'b1;
                end else begin
                    dcnt <= dcnt + 6'h01;
                end
            end
        end
    end

    // apb answer: ready in the access phase, unmapped addresses flag an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr > `PVB_OFF_SRST || paddr[1:0] != 2'h0);
            prdata <= 32'h00000000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `PVB_OFF_CTRL: prdata <= {26'h0, video_control_reg};
                    `PVB_OFF_VMAR: prdata <= {16'h0, stg.vmargin};
                    `PVB_OFF_HMAR: prdata <= {16'h0, stg.hmargin};
                    `PVB_OFF_HGT: prdata <= {16'h0, stg.height};
                    `PVB_OFF_WID: prdata <= {16'h0, stg.width};
                    `PVB_OFF_BCTL: prdata <= {31'h0, stg.band};
                    `PVB_OFF_ADDR: prdata <= {8'h0, stg.addr};
                    `PVB_OFF_EVT: prdata <= {22'h0, video_busy_flag, control_block_full_flag,
                        3'h0, video_event_status};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // control register and staged control block; soft reset pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            video_control_reg <= `PVB_CTRL_RST; // RULE22
            stg <= '0;
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= wr && paddr == `PVB_OFF_SRST && pwdata[0]; // RULE2 RULE22
            if (wr) begin
                case (paddr)
                    `PVB_OFF_CTRL: video_control_reg <= pwdata[5:0];
                    `PVB_OFF_VMAR: stg.vmargin <= pwdata[15:0]; // RULE4
                    `PVB_OFF_HMAR: stg.hmargin <= pwdata[15:0];
                    `PVB_OFF_HGT: stg.height <= pwdata[15:0];
                    `PVB_OFF_WID: stg.width <= pwdata[15:0];
                    `PVB_OFF_BCTL: stg.band <= pwdata[0]; // RULE23
                    `PVB_OFF_ADDR: stg.addr <= pwdata[23:0];
                    default: stg <= stg;
                endcase
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            print_out <= 1'b0;
        end else begin
            print_out <= video_control_reg.pout;
        end
    end

    // active control block taken from the staged copy when the sequencer is free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act <= '0;
        end else if (take) begin
            act <= stg;
        end
    end

    // block-full and busy flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_block_full_flag <= 1'b0;
            video_busy_flag <= 1'b0;
        end else if (soft_rst) begin
            control_block_full_flag <= 1'b0;
            video_busy_flag <= 1'b0;
        end else if (wr && paddr == `PVB_OFF_ADDR) begin
            control_block_full_flag <= 1'b1; // RULE11
            video_busy_flag <= 1'b1; // RULE3
        end else begin
            if (take) begin
                control_block_full_flag <= 1'b0; // RULE11
            end
            if (f_done && !control_block_full_flag) begin
                video_busy_flag <= 1'b0; // RULE16
            end
        end
    end

    // event flags: write one to clear, a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            video_event_status <= 5'h00;
        end else begin
            video_event_status <= (video_event_status &
                ~((wr && paddr == `PVB_OFF_EVT) ? pwdata[4:0] : 5'h00)) |
                {f_bad, f_bun, seq_vun, f_end, seq_beg | f_beg}; // RULE1
        end
    end

    // image fetch: one word outstanding, fifo filled while room remains
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_cmd <= '0;
            fetch_on <= 1'b0;
            faddr <= 20'h00000;
            fwords <= 13'h0000;
            flines <= 16'h0000;
            first_fetch <= 1'b0;
            wr_ptr <= 3'h0;
            f_beg <= 1'b0;
            f_end <= 1'b0;
            f_bun <= 1'b0;
            f_bad <= 1'b0;
            f_done <= 1'b0;
        end else begin
            f_beg <= 1'b0;
            f_end <= 1'b0;
            f_bun <= 1'b0;
            f_bad <= 1'b0;
            f_done <= 1'b0;
            if (soft_rst) begin
                mem_cmd <= '0;
                fetch_on <= 1'b0;
                wr_ptr <= 3'h0;
            end else if (take) begin
                fetch_on <= stg.height != 16'h0000 && stg.width != 16'h0000;
                f_done <= stg.height == 16'h0000 || stg.width == 16'h0000;
                faddr <= stg.addr[23:4];
                fwords <= 13'h0000;
                flines <= stg.height;
                first_fetch <= st == S_BAND;
                wr_ptr <= rd_ptr;
            end else if (fetch_on && st != S_HALT) begin
                if (fwords == 13'h0000) begin
                    fwords <= wpl;
                end else if (!mem_cmd.req) begin
                    if (faddr >= `PVB_MEM_LIMIT) begin
                        f_bad <= 1'b1; // RULE10
                        fetch_on <= 1'b0;
                    end else if ({1'b0, fcount} < `PVB_FIFO_DEPTH) begin
                        mem_cmd.req <= 1'b1;
                        mem_cmd.addr <= faddr;
                    end
                end else if (mem_rsp.ack) begin
                    mem_cmd.req <= 1'b0;
                    if (mem_rsp.err) begin
                        f_bad <= 1'b1; // RULE10
                        fetch_on <= 1'b0;
                    end else begin
                        fifo_mem[wr_ptr[1:0]] <= mem_rsp.data;
                        wr_ptr <= wr_ptr + 3'h1;
                        faddr <= faddr + 20'h00001;
                        first_fetch <= 1'b0;
                        f_beg <= first_fetch; // RULE6
                        if (fwords == 13'h0001 && flines == 16'h0001) begin
                            fetch_on <= 1'b0; // RULE16
                            f_done <= 1'b1;
                            f_end <= !act.band; // RULE7
                            f_bun <= act.band && !control_block_full_flag; // RULE8
                        end else if (fwords == 13'h0001) begin
                            flines <= flines - 16'h0001;
                            fwords <= wpl;
                        end else begin
                            fwords <= fwords - 13'h0001;
                        end
                    end
                end
            end
        end
    end

    // video sequencer: syncs, margins, shifting, width and height counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= S_IDLE;
            vm_cnt <= 16'h0000;
            hm_cnt <= 16'h0000;
            wcnt <= 16'h0000;
            lines <= 16'h0000;
            sh_reg <= 16'h0000;
            sh_cnt <= 5'h00;
            rd_ptr <= 3'h0;
            video_out <= 1'b0;
            seq_beg <= 1'b0;
            seq_vun <= 1'b0;
        end else begin
            seq_beg <= 1'b0;
            seq_vun <= 1'b0;
            if (soft_rst) begin
                st <= S_IDLE; // RULE2
                rd_ptr <= 3'h0;
                sh_cnt <= 5'h00;
                video_out <= 1'b0;
            end else if (f_bad) begin
                st <= S_HALT; // RULE10
                video_out <= 1'b0;
            end else begin
                case (st)
                    S_IDLE, S_BAND: begin
                        if (take) begin
                            vm_cnt <= (st == S_BAND) ? 16'h0000 : stg.vmargin;
                            lines <= stg.height;
                            st <= (st == S_BAND) ? S_LINE : S_FRAME;
                        end
                    end
                    S_FRAME: begin
                        if (frame_rise) begin
                            seq_beg <= 1'b1; // RULE5 RULE12
                            st <= S_LINE;
                        end
                    end
                    S_LINE: begin
                        if (line_rise) begin
                            if (vm_cnt != 16'h0000) begin
                                vm_cnt <= vm_cnt - 16'h0001; // RULE13
                            end else begin
                                hm_cnt <= act.hmargin;
                                wcnt <= act.width;
                                sh_cnt <= 5'h00;
                                st <= (act.hmargin == 16'h0000) ? S_ACT : S_HMAR; // RULE21
                            end
                        end
                    end
                    S_HMAR: begin
                        if (dot_tick) begin
                            hm_cnt <= hm_cnt - 16'h0001; // RULE13
                            if (hm_cnt == 16'h0001) begin
                                st <= S_ACT;
                            end
                        end
                    end
                    S_ACT: begin
                        if (dot_tick) begin
                            if (wcnt == 16'h0000) begin
                                video_out <= 1'b0;
                                if (lines <= 16'h0001) begin
                                    st <= act.band ? S_BAND : S_IDLE; // RULE17
                                end else begin
                                    lines <= lines - 16'h0001; // RULE15
                                    st <= S_LINE;
                                end
                            end else begin
                                wcnt <= wcnt - 16'h0001; // RULE15
                                if (sh_cnt == 5'h00) begin
                                    sh_cnt <= `PVB_WORD_BITS - 5'h01; // RULE14
                                    if (fifo_empty) begin
                                        seq_vun <= 1'b1; // RULE9
                                        video_out <= 1'b0;
                                        sh_reg <= 16'h0000;
                                    end else begin
                                        video_out <= fifo_mem[rd_ptr[1:0]][15];
                                        sh_reg <= {fifo_mem[rd_ptr[1:0]][14:0], 1'b0};
                                        rd_ptr <= rd_ptr + 3'h1;
                                    end
                                end else begin
                                    video_out <= sh_reg[15]; // RULE14
                                    sh_reg <= {sh_reg[14:0], 1'b0};
                                    sh_cnt <= sh_cnt - 5'h01;
                                end
                            end
                        end
                    end
                    S_HALT: st <= S_HALT;
                    default: st <= S_IDLE;
                endcase
            end
        end
    end

    property p_start_flags;
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == `PVB_OFF_ADDR && !soft_rst |=> control_block_full_flag && video_busy_flag;
    endproperty
    a_start_flags: assert property (p_start_flags) else $error("start did not set flags"); // RULE11

    property p_take_clears;
        @(posedge pclk) disable iff (!presetn)
        take && !wr |=> !control_block_full_flag ##0 st != S_IDLE || !$past(st == S_IDLE);
    endproperty
    a_take_clears: assert property (p_take_clears) else $error("full not cleared on start"); // RULE11

    property p_frame_begin;
        @(posedge pclk) disable iff (!presetn || soft_rst)
        st == S_FRAME && frame_rise && !f_bad |=> st == S_LINE ##1 video_event_status[`PVB_EV_BEG];
    endproperty
    a_frame_begin: assert property (p_frame_begin) else $error("begin not posted"); // RULE5

    property p_halt;
        @(posedge pclk) disable iff (!presetn)
        f_bad && !soft_rst |=> st == S_HALT && video_event_status[`PVB_EV_BAD];
    endproperty
    a_halt: assert property (p_halt) else $error("address error did not halt"); // RULE10

    property p_underrun;
        @(posedge pclk) disable iff (!presetn || soft_rst || f_bad)
        st == S_ACT && dot_tick && wcnt != 16'h0000 && sh_cnt == 5'h00 && fifo_empty
        |=> ##1 video_event_status[`PVB_EV_VUN];
    endproperty
    a_underrun: assert property (p_underrun) else $error("video underrun missed"); // RULE9

    property p_shift;
        @(posedge pclk) disable iff (!presetn || soft_rst || f_bad)
        st == S_ACT && dot_tick && wcnt != 16'h0000 && sh_cnt != 5'h00
        |=> video_out == $past(sh_reg[15]) && sh_cnt == $past(sh_cnt) - 5'h01;
    endproperty
    a_shift: assert property (p_shift) else $error("shift out wrong"); // RULE14

    property p_sync_tick;
        @(posedge pclk) disable iff (!presetn)
        !video_control_reg.src && video_control_reg.edge_sel && clk_rise |=> dot_tick;
    endproperty
    a_sync_tick: assert property (p_sync_tick) else $error("engine edge not used"); // RULE18

    property p_vmargin;
        @(posedge pclk) disable iff (!presetn || soft_rst || f_bad)
        st == S_LINE && line_rise && vm_cnt != 16'h0000
        |=> st == S_LINE && vm_cnt == $past(vm_cnt) - 16'h0001;
    endproperty
    a_vmargin: assert property (p_vmargin) else $error("vertical margin not counted"); // RULE13

    property p_page_end;
        @(posedge pclk) disable iff (!presetn)
        f_done && !act.band && !$past(take) |=> video_event_status[`PVB_EV_END];
    endproperty
    a_page_end: assert property (p_page_end) else $error("page end missing"); // RULE7
endmodule : pvb_top

// ==== pvb_engine.sv ====
// print engine and image memory model for the band controller bench
`timescale 1ns/1ps
module pvb_engine (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic [7:0] lat,
    input wire pvb_pkg::pvb_memreq_t mem_cmd,
    output pvb_pkg::pvb_memrsp_t mem_rsp,
    output logic frame_sync_in,
    output logic line_sync_in,
    output logic engine_dot_clock_in
);
    import pvb_pkg::*;
    logic [15:0] dcnt;
    logic [7:0] wcnt;
    // free-running dot clock, phase unrelated to pclk
    initial begin
        engine_dot_clock_in = 1'b0;
        #37;
        forever #100 engine_dot_clock_in = ~engine_dot_clock_in;
    end
    // syncs move on the falling edge so they are steady at the rising one
    always @(negedge engine_dot_clock_in) begin
        dcnt <= go ? dcnt + 16'h1 : 16'h0;
        frame_sync_in <= go && dcnt[15:1] == 15'h1;
        line_sync_in <= go && dcnt % 100 >= 50 && dcnt % 100 < 52;
    end
    // memory answers after lat cycles with the inverted word address as data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_rsp <= '0;
            wcnt <= 8'h0;
        end else if (mem_rsp.ack) begin
            mem_rsp <= '0;
            wcnt <= 8'h0;
        end else if (mem_cmd.req && wcnt == lat) begin
            mem_rsp <= {2'b10, ~mem_cmd.addr[15:0]};
        end else begin
            mem_rsp <= {2'b00, ~mem_rsp.data};
            wcnt <= mem_cmd.req ? wcnt + 8'h1 : 8'h0;
        end
    end
endmodule : pvb_engine

// ==== tb.sv ====
// self-checking bench for the print video band controller
`timescale 1ns/1ps
`include "pvb_defs.svh"
module tb;
    import pvb_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, go, pready, pslverr, err;
    logic fs, ls, dck, video_out, print_out;
    logic [7:0] paddr, lat;
    logic [31:0] pwdata, prdata, rd;
    pvb_memreq_t mem_cmd;
    pvb_memrsp_t mem_rsp;
    int n_errors = 0, num_checks = 0, cyc = 0, vcnt = 0, v0;
    pvb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_cmd(mem_cmd), .mem_rsp(mem_rsp), .frame_sync_in(fs),
        .line_sync_in(ls), .engine_dot_clock_in(dck), .video_out(video_out),
        .print_out(print_out));
    pvb_engine eng (.pclk(pclk), .presetn(presetn), .go(go), .lat(lat), .mem_cmd(mem_cmd),
        .mem_rsp(mem_rsp), .frame_sync_in(fs), .line_sync_in(ls), .engine_dot_clock_in(dck));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // hang guard and tally of cycles with video high
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        vcnt <= vcnt + int'(video_out);
        if (cyc == 40000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one apb transfer, then one idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rs(input logic [31:0] m, input logic [31:0] e, input string nm);
        apb(1'b0, `PVB_OFF_EVT, 32'h0);
        chk(nm, rd & m, e);
    endtask : rs
    // control block loaded while it is free, address last
    task automatic start(input logic [15:0] v, h, g, w, input logic b, input logic [23:0] a);
        wr(`PVB_OFF_VMAR, {16'h0, v});
        wr(`PVB_OFF_HMAR, {16'h0, h});
        wr(`PVB_OFF_HGT, {16'h0, g});
        wr(`PVB_OFF_WID, {16'h0, w});
        wr(`PVB_OFF_BCTL, {31'h0, b});
        wr(`PVB_OFF_ADDR, {8'h0, a});
    endtask : start
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        go = 1'b0;
        lat = 8'h14;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `PVB_OFF_CTRL, 32'h0);
        chk("ctrl reset", rd, 32'h0);
        rs(32'h31f, 32'h0, "status reset");
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped", {rd[30:0], err}, 32'h1);
        // synchronous page, two lines of one word
        wr(`PVB_OFF_CTRL, 32'h6);
        start(16'h1, 16'h2, 16'h2, 16'h10, 1'b0, 24'h100);
        chk("print on", {31'h0, print_out}, 32'h1);
        rs(32'h200, 32'h200, "busy");
        repeat (60) @(posedge pclk);
        rs(32'h203, 32'h2, "fetch done");
        v0 = vcnt;
        go <= 1'b1;
        repeat (2600) @(posedge pclk);
        rs(32'h1, 32'h1, "begin");
        chk("sync dots", vcnt - v0, 32'd232);
        wr(`PVB_OFF_EVT, 32'h1f);
        rs(32'h1f, 32'h0, "clear");
        go <= 1'b0;
        // divided clock page, dot is four engine clocks
        wr(`PVB_OFF_CTRL, 32'h3);
        wr(`PVB_OFF_SRST, 32'h1);
        start(16'h1, 16'h2, 16'h2, 16'h10, 1'b0, 24'h100);
        chk("print off", {31'h0, print_out}, 32'h0);
        v0 = vcnt;
        go <= 1'b1;
        repeat (3200) @(posedge pclk);
        chk("async dots", vcnt - v0, 32'd928);
        go <= 1'b0;
        wr(`PVB_OFF_CTRL, 32'h6);
        wr(`PVB_OFF_SRST, 32'h1);
        wr(`PVB_OFF_EVT, 32'h1f);
        // continued band with no next address
        start(16'h1, 16'h2, 16'h2, 16'h10, 1'b1, 24'h100);
        repeat (60) @(posedge pclk);
        rs(32'h1e, 32'h8, "band underrun");
        wr(`PVB_OFF_SRST, 32'h1);
        wr(`PVB_OFF_EVT, 32'h1f);
        // fetch beyond the end of memory
        start(16'h1, 16'h2, 16'h2, 16'h10, 1'b0, 24'h800000);
        repeat (40) @(posedge pclk);
        rs(32'h10, 32'h10, "illegal");
        wr(`PVB_OFF_SRST, 32'h1);
        rs(32'h300, 32'h0, "soft reset");
        wr(`PVB_OFF_EVT, 32'h1f);
        // memory too slow for the dot rate
        lat <= 8'hff;
        start(16'h0, 16'h0, 16'h1, 16'h60, 1'b0, 24'h100);
        go <= 1'b1;
        repeat (1500) @(posedge pclk);
        rs(32'h4, 32'h4, "video underrun");
        stop_test();
    end
endmodule : tb
